//--- verilog/crm_core_regs.sv
// Core register file with two address generators and stack checking

// Function
// - Unimplemented register bits read zero and ignore writes, except accumulator upper bits 15:8 (sign extension of bit 7) and circular end bit 0 (reads one).
// - Two independent address generators, primary and secondary.
// - Secondary generator serves only word reads of multiply-accumulate instructions.
// - Linear and circular modes work for data and program space.
// - Bit-reversed mode only on the primary generator and only for data space, never program space.
// - Odd word access traps; reads complete, writes are suppressed.
// - Push at a nonzero stack limit does not trap; next push beyond it does.
// - Stack pointer below 0x0800 raises stack error trap.
// - Stack pointer grows upward, post-increment push, pre-decrement pop.
module crm_core_regs
  import crm_pkg::*;
(
  input  wire logic          CLK_I,
  input  wire logic          RST_I,
  input  wire logic          CE_I,
  input  wire logic [15:0]   ADDR_I,
  input  wire logic [15:0]   WDATA_I,
  input  wire logic          WR_I,
  input  wire logic          RD_I,
  output logic      [15:0]   RDATA_O,
  input  wire crm_agu_req_t  XREQ_I,
  input  wire crm_agu_req_t  YREQ_I,
  output crm_agu_rsp_t       XRSP_O,
  output crm_agu_rsp_t       YRSP_O,
  input  wire crm_stack_op_t STACK_OP_I,
  output logic               ADDR_TRAP_O,
  output logic               STACK_TRAP_O,
  output logic               IRQ_O
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] wreg [0:4];
  logic [15:0] frame_ptr;
  logic [15:0] stack_ptr;
  logic [15:0] stk_limit;
  logic [15:0] acca_lo, acca_hi, acca_up;
  logic [15:0] accb_lo, accb_hi, accb_up;
  logic [15:0] pc_lo, pc_hi, tbl_page, psv_page;
  logic [15:0] rep_cnt, loop_cnt;
  logic [15:0] lstart_lo, lstart_hi, lend_lo, lend_hi;
  logic [15:0] status, core_ctl, circ_ctl;
  logic [15:0] xc_start, xc_end, yc_start, yc_end;
  logic [15:0] brev_ctl, dis_cnt, boot_prot, sec_prot;
  logic [15:0] trap_stat, trap_mask;

  logic        wr_en;
  logic        rd_en;
  logic [15:0] next_rdata;
  logic        push_ev, pop_ev;
  logic        stk_err_ev;
  logic        x_odd_ev, y_odd_ev, y_misuse_ev;
  logic [2:0]  trap_ev;

  assign wr_en = CE_I && WR_I;
  assign rd_en = CE_I && RD_I;

  // ----------------------------------------------------------------
  // Working registers 9..13
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_wreg
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          wreg[gi] <= RST_ZERO;
        end else if (wr_en && ADDR_I == OFS_WREG9 + 16'(2 * gi)) begin
          wreg[gi] <= WDATA_I;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Stack pointer and frame pointer
  // ----------------------------------------------------------------
  assign push_ev = CE_I && STACK_OP_I == CRM_OP_PUSH;
  assign pop_ev  = CE_I && STACK_OP_I == CRM_OP_POP;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      stack_ptr <= RST_STACK_PTR;
    end else if (push_ev) begin
      stack_ptr <= stack_ptr + 16'h0002;
    end else if (pop_ev) begin
      stack_ptr <= stack_ptr - 16'h0002;
    end else if (wr_en && ADDR_I == OFS_STACK_PTR) begin
      stack_ptr <= WDATA_I & MSK_EVEN;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      frame_ptr <= RST_ZERO;
      stk_limit <= RST_ZERO;
    end else if (wr_en) begin
      if (ADDR_I == OFS_FRAME_PTR) begin
        frame_ptr <= WDATA_I;
      end
      if (ADDR_I == OFS_STK_LIMIT) begin
        stk_limit <= WDATA_I & MSK_EVEN;
      end
    end
  end

  // trap on push beyond a nonzero limit, or on any CE_I cycle with pointer below STACK_FLOOR
  assign stk_err_ev = (push_ev && stack_ptr > stk_limit && stk_limit != RST_ZERO) ||
                      (CE_I && stack_ptr < STACK_FLOOR);

  // ----------------------------------------------------------------
  // Accumulators, program counter, pages, loop registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      acca_lo   <= RST_ZERO;
      acca_hi   <= RST_ZERO;
      acca_up   <= RST_ZERO;
      accb_lo   <= RST_ZERO;
      accb_hi   <= RST_ZERO;
      accb_up   <= RST_ZERO;
      pc_lo     <= RST_ZERO;
      pc_hi     <= RST_ZERO;
      tbl_page  <= RST_ZERO;
      psv_page  <= RST_ZERO;
      rep_cnt   <= RST_ZERO;
      loop_cnt  <= RST_ZERO;
      lstart_lo <= RST_ZERO;
      lstart_hi <= RST_ZERO;
      lend_lo   <= RST_ZERO;
      lend_hi   <= RST_ZERO;
    end else if (wr_en) begin
      case (ADDR_I)
        OFS_ACCA_LO:   acca_lo   <= WDATA_I;
        OFS_ACCA_HI:   acca_hi   <= WDATA_I;
        OFS_ACCA_UP:   acca_up   <= WDATA_I & MSK_ACC_UP;
        OFS_ACCB_LO:   accb_lo   <= WDATA_I;
        OFS_ACCB_HI:   accb_hi   <= WDATA_I;
        OFS_ACCB_UP:   accb_up   <= WDATA_I & MSK_ACC_UP;
        OFS_PC_LO:     pc_lo     <= WDATA_I & MSK_EVEN;
        OFS_PC_HI:     pc_hi     <= WDATA_I & MSK_PC_HI;
        OFS_TBL_PAGE:  tbl_page  <= WDATA_I & MSK_TBL_PAGE;
        OFS_PSV_PAGE:  psv_page  <= WDATA_I & MSK_PSV_PAGE;
        OFS_REP_CNT:   rep_cnt   <= WDATA_I;
        OFS_LOOP_CNT:  loop_cnt  <= WDATA_I;
        OFS_LSTART_LO: lstart_lo <= WDATA_I & MSK_EVEN;
        OFS_LSTART_HI: lstart_hi <= WDATA_I & MSK_LOOP_HI;
        OFS_LEND_LO:   lend_lo   <= WDATA_I & MSK_EVEN;
        OFS_LEND_HI:   lend_hi   <= WDATA_I & MSK_LOOP_HI;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status, control, circular and bit-reverse registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      status    <= RST_ZERO;
      core_ctl  <= RST_CORE_CTL;
      circ_ctl  <= RST_ZERO;
      xc_start  <= RST_ZERO;
      xc_end    <= ~MSK_EVEN;
      yc_start  <= RST_ZERO;
      yc_end    <= ~MSK_EVEN;
      brev_ctl  <= RST_ZERO;
      dis_cnt   <= RST_ZERO;
      boot_prot <= RST_ZERO;
      sec_prot  <= RST_ZERO;
      trap_mask <= RST_ZERO;
    end else if (wr_en) begin
      case (ADDR_I)
        OFS_STATUS:    status    <= WDATA_I;
        OFS_CORE_CTL:  core_ctl  <= WDATA_I & MSK_CORE_CTL;
        OFS_CIRC_CTL:  circ_ctl  <= WDATA_I & MSK_CIRC_CTL;
        OFS_XC_START:  xc_start  <= WDATA_I & MSK_EVEN;
        OFS_XC_END:    xc_end    <= WDATA_I | ~MSK_EVEN;
        OFS_YC_START:  yc_start  <= WDATA_I & MSK_EVEN;
        OFS_YC_END:    yc_end    <= WDATA_I | ~MSK_EVEN;
        OFS_BREV_CTL:  brev_ctl  <= WDATA_I;
        OFS_DIS_CNT:   dis_cnt   <= WDATA_I & MSK_DIS_CNT;
        OFS_BOOT_PROT: boot_prot <= WDATA_I & MSK_BOOT_PROT;
        OFS_SEC_PROT:  sec_prot  <= WDATA_I & MSK_SEC_PROT;
        OFS_TRAP_MASK: trap_mask <= WDATA_I & MSK_TRAP;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address generators
  // ----------------------------------------------------------------
  function automatic logic [15:0] agu_next(input crm_agu_req_t req, input logic circ_en,
                                           input logic [15:0] c_start,
                                           input logic [15:0] c_end,
                                           input logic [15:0] brev);
    logic [15:0] sum;
    logic [15:0] rev;
    sum = req.base + req.step;
    rev = RST_ZERO;
    for (int b = 0; b < 15; b++) begin
      rev[b] = req.base[14 - b];
    end
    if (req.mode == CRM_MODE_CIRC && circ_en) begin
      if (sum > c_end) begin
        sum = c_start + (sum - c_end - 16'h0001);
      end else if (sum < c_start) begin
        sum = c_end + 16'h0001 - (c_start - sum);
      end
    // reverse carry only in data space
    end else if (req.mode == CRM_MODE_BREV && brev[BREV_EN] && !req.prog_space) begin
      sum = {1'b0, rev[14:0] + brev[14:0]};
      for (int b = 0; b < 15; b++) begin
        rev[b] = sum[14 - b];
      end
      sum = {req.base[15], rev[14:0]};
    end
    return sum;
  endfunction

  assign x_odd_ev = CE_I && XREQ_I.valid && XREQ_I.word && XREQ_I.base[0];
  // secondary unit takes only word reads of MAC class
  assign y_misuse_ev = CE_I && YREQ_I.valid &&
                       (YREQ_I.write || !YREQ_I.word || !YREQ_I.mac_read || YREQ_I.prog_space);
  assign y_odd_ev = CE_I && YREQ_I.valid && YREQ_I.base[0];

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      XRSP_O <= '0;
    end else if (CE_I) begin
      XRSP_O.valid    <= XREQ_I.valid;
      XRSP_O.addr     <= XREQ_I.base;
      XRSP_O.write_ok <= XREQ_I.valid && XREQ_I.write && !(XREQ_I.word && XREQ_I.base[0]);
      XRSP_O.next_ptr <= agu_next(XREQ_I, circ_ctl[CC_X_EN], xc_start, xc_end, brev_ctl);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      YRSP_O <= '0;
    end else if (CE_I) begin
      YRSP_O.valid    <= YREQ_I.valid && !y_misuse_ev;
      YRSP_O.addr     <= YREQ_I.base;
      YRSP_O.write_ok <= 1'b0;
      YRSP_O.next_ptr <= agu_next(YREQ_I, circ_ctl[CC_Y_EN], yc_start, yc_end, RST_ZERO);
    end
  end

  // ----------------------------------------------------------------
  // Trap status and interrupt
  // ----------------------------------------------------------------
  assign trap_ev[TRAP_ADDR]  = x_odd_ev || y_odd_ev;
  assign trap_ev[TRAP_STK]   = stk_err_ev;
  assign trap_ev[TRAP_ROUTE] = y_misuse_ev;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      trap_stat <= RST_ZERO;
    end else if (CE_I) begin
      // Set wins over write-one-to-clear
      if (wr_en && ADDR_I == OFS_TRAP_STAT) begin
        trap_stat <= (trap_stat & ~(WDATA_I & MSK_TRAP)) | {13'h0000, trap_ev};
      end else begin
        trap_stat <= trap_stat | {13'h0000, trap_ev};
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ADDR_TRAP_O  <= 1'b0;
      STACK_TRAP_O <= 1'b0;
    end else if (CE_I) begin
      ADDR_TRAP_O  <= trap_ev[TRAP_ADDR];
      STACK_TRAP_O <= trap_ev[TRAP_STK];
    end
  end

  assign IRQ_O = |(trap_stat & trap_mask);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    case (ADDR_I)
      OFS_WREG9:     next_rdata = wreg[0];
      OFS_WREG10:    next_rdata = wreg[1];
      OFS_WREG11:    next_rdata = wreg[2];
      OFS_WREG12:    next_rdata = wreg[3];
      OFS_WREG13:    next_rdata = wreg[4];
      OFS_FRAME_PTR: next_rdata = frame_ptr;
      OFS_STACK_PTR: next_rdata = stack_ptr;
      OFS_STK_LIMIT: next_rdata = stk_limit;
      OFS_ACCA_LO:   next_rdata = acca_lo;
      OFS_ACCA_HI:   next_rdata = acca_hi;
      OFS_ACCA_UP:   next_rdata = {{8{acca_up[7]}}, acca_up[7:0]};
      OFS_ACCB_LO:   next_rdata = accb_lo;
      OFS_ACCB_HI:   next_rdata = accb_hi;
      OFS_ACCB_UP:   next_rdata = {{8{accb_up[7]}}, accb_up[7:0]};
      OFS_PC_LO:     next_rdata = pc_lo;
      OFS_PC_HI:     next_rdata = pc_hi;
      OFS_TBL_PAGE:  next_rdata = tbl_page;
      OFS_PSV_PAGE:  next_rdata = psv_page;
      OFS_REP_CNT:   next_rdata = rep_cnt;
      OFS_LOOP_CNT:  next_rdata = loop_cnt;
      OFS_LSTART_LO: next_rdata = lstart_lo;
      OFS_LSTART_HI: next_rdata = lstart_hi;
      OFS_LEND_LO:   next_rdata = lend_lo;
      OFS_LEND_HI:   next_rdata = lend_hi;
      OFS_STATUS:    next_rdata = status;
      OFS_CORE_CTL:  next_rdata = core_ctl;
      OFS_CIRC_CTL:  next_rdata = circ_ctl;
      OFS_XC_START:  next_rdata = xc_start;
      OFS_XC_END:    next_rdata = xc_end;
      OFS_YC_START:  next_rdata = yc_start;
      OFS_YC_END:    next_rdata = yc_end;
      OFS_BREV_CTL:  next_rdata = brev_ctl;
      OFS_DIS_CNT:   next_rdata = dis_cnt;
      OFS_TRAP_STAT: next_rdata = trap_stat;
      OFS_TRAP_MASK: next_rdata = trap_mask;
      OFS_BOOT_PROT: next_rdata = boot_prot;
      OFS_SEC_PROT:  next_rdata = sec_prot;
      default:       next_rdata = RST_ZERO;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RDATA_O <= RST_ZERO;
    end else if (rd_en) begin
      RDATA_O <= next_rdata;
    end else if (CE_I) begin
      RDATA_O <= RST_ZERO;
    end
  end

endmodule

//--- verilog/crm_pkg.sv
// Package: core register map constants, layouts and address generator types
package crm_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_WREG9     = 16'h0012;
  localparam logic [15:0] OFS_WREG10    = 16'h0014;
  localparam logic [15:0] OFS_WREG11    = 16'h0016;
  localparam logic [15:0] OFS_WREG12    = 16'h0018;
  localparam logic [15:0] OFS_WREG13    = 16'h001A;
  localparam logic [15:0] OFS_FRAME_PTR = 16'h001C;
  localparam logic [15:0] OFS_STACK_PTR = 16'h001E;
  localparam logic [15:0] OFS_STK_LIMIT = 16'h0020;
  localparam logic [15:0] OFS_ACCA_LO   = 16'h0022;
  localparam logic [15:0] OFS_ACCA_HI   = 16'h0024;
  localparam logic [15:0] OFS_ACCA_UP   = 16'h0026;
  localparam logic [15:0] OFS_ACCB_LO   = 16'h0028;
  localparam logic [15:0] OFS_ACCB_HI   = 16'h002A;
  localparam logic [15:0] OFS_ACCB_UP   = 16'h002C;
  localparam logic [15:0] OFS_PC_LO     = 16'h002E;
  localparam logic [15:0] OFS_PC_HI     = 16'h0030;
  localparam logic [15:0] OFS_TBL_PAGE  = 16'h0032;
  localparam logic [15:0] OFS_PSV_PAGE  = 16'h0034;
  localparam logic [15:0] OFS_REP_CNT   = 16'h0036;
  localparam logic [15:0] OFS_LOOP_CNT  = 16'h0038;
  localparam logic [15:0] OFS_LSTART_LO = 16'h003A;
  localparam logic [15:0] OFS_LSTART_HI = 16'h003C;
  localparam logic [15:0] OFS_LEND_LO   = 16'h003E;
  localparam logic [15:0] OFS_LEND_HI   = 16'h0040;
  localparam logic [15:0] OFS_STATUS    = 16'h0042;
  localparam logic [15:0] OFS_CORE_CTL  = 16'h0044;
  localparam logic [15:0] OFS_CIRC_CTL  = 16'h0046;
  localparam logic [15:0] OFS_XC_START  = 16'h0048;
  localparam logic [15:0] OFS_XC_END    = 16'h004A;
  localparam logic [15:0] OFS_YC_START  = 16'h004C;
  localparam logic [15:0] OFS_YC_END    = 16'h004E;
  localparam logic [15:0] OFS_BREV_CTL  = 16'h0050;
  localparam logic [15:0] OFS_DIS_CNT   = 16'h0052;
  localparam logic [15:0] OFS_TRAP_STAT = 16'h0054;
  localparam logic [15:0] OFS_TRAP_MASK = 16'h0056;
  localparam logic [15:0] OFS_BOOT_PROT = 16'h0750;
  localparam logic [15:0] OFS_SEC_PROT  = 16'h0752;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MSK_ACC_UP    = 16'h00FF;
  localparam logic [15:0] MSK_PC_HI     = 16'h007F;
  localparam logic [15:0] MSK_TBL_PAGE  = 16'h007F;
  localparam logic [15:0] MSK_PSV_PAGE  = 16'h00FF;
  localparam logic [15:0] MSK_LOOP_HI   = 16'h007F;
  localparam logic [15:0] MSK_EVEN      = 16'hFFFE;
  localparam logic [15:0] MSK_CORE_CTL  = 16'h1FFF;
  localparam logic [15:0] MSK_CIRC_CTL  = 16'hCFFF;
  localparam logic [15:0] MSK_DIS_CNT   = 16'h3FFF;
  localparam logic [15:0] MSK_BOOT_PROT = 16'h0007;
  localparam logic [15:0] MSK_SEC_PROT  = 16'h0007;
  localparam logic [15:0] MSK_TRAP      = 16'h0007;
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [15:0] RST_STACK_PTR = 16'h0800;
  localparam logic [15:0] RST_CORE_CTL  = 16'h0020;
  localparam logic [15:0] STACK_FLOOR   = 16'h0800;

  // Circular and bit-reverse control fields
  localparam int CC_X_EN  = 15;
  localparam int CC_Y_EN  = 14;
  localparam int BREV_EN  = 15;

  // Trap status bits
  localparam int TRAP_ADDR = 0;
  localparam int TRAP_STK  = 1;
  localparam int TRAP_ROUTE = 2;

  // ----------------------------------------------------------------
  // Address generator and stack operation types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CRM_MODE_LINEAR = 2'b00,
    CRM_MODE_CIRC   = 2'b01,
    CRM_MODE_BREV   = 2'b10
  } crm_mode_t;

  typedef enum logic [1:0] {
    CRM_OP_NONE = 2'b00,
    CRM_OP_PUSH = 2'b01,
    CRM_OP_POP  = 2'b10
  } crm_stack_op_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic        mac_read;
    logic        prog_space;
    crm_mode_t   mode;
    logic [15:0] base;
    logic [15:0] step;
  } crm_agu_req_t;

  typedef struct packed {
    logic        valid;
    logic        write_ok;
    logic [15:0] addr;
    logic [15:0] next_ptr;
  } crm_agu_rsp_t;

endpackage

//--- bench/crm_core_regs_properties.sv
// Checker: port-level properties of the core register file
module crm_core_regs_properties
  import crm_pkg::*;
(
  input wire logic          CLK_I,
  input wire logic          RST_I,
  input wire logic          CE_I,
  input wire logic [15:0]   ADDR_I,
  input wire logic [15:0]   WDATA_I,
  input wire logic          WR_I,
  input wire logic          RD_I,
  input wire logic [15:0]   RDATA_O,
  input wire crm_agu_req_t  XREQ_I,
  input wire crm_agu_req_t  YREQ_I,
  input wire crm_agu_rsp_t  XRSP_O,
  input wire crm_agu_rsp_t  YRSP_O,
  input wire crm_stack_op_t STACK_OP_I,
  input wire logic          ADDR_TRAP_O,
  input wire logic          STACK_TRAP_O,
  input wire logic          IRQ_O
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] imp_mask;
  logic [15:0] last_mask;
  logic [15:0] x_sum;

  // ------------------------------------------------------------
  // Implemented bits of the addressed register
  // ------------------------------------------------------------
  always_comb begin
    case (ADDR_I)
      OFS_PC_HI, OFS_TBL_PAGE, OFS_LSTART_HI, OFS_LEND_HI: imp_mask = MSK_LOOP_HI;
      OFS_PSV_PAGE:                                       imp_mask = MSK_PSV_PAGE;
      OFS_LSTART_LO, OFS_LEND_LO:                         imp_mask = MSK_EVEN;
      OFS_CORE_CTL:                                       imp_mask = MSK_CORE_CTL;
      OFS_CIRC_CTL:                                       imp_mask = MSK_CIRC_CTL;
      OFS_DIS_CNT:                                        imp_mask = MSK_DIS_CNT;
      OFS_BOOT_PROT, OFS_SEC_PROT, OFS_TRAP_STAT:         imp_mask = MSK_TRAP;
      default:                                            imp_mask = 16'hFFFF;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    last_mask <= imp_mask;
    x_sum     <= XREQ_I.base + XREQ_I.step;
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_unimpl_zero: assert property (
    CE_I && RD_I |=> (RDATA_O & ~last_mask) == 16'h0000)
    else $error("unimplemented bits read nonzero");
  a_unmapped_zero: assert property (
    CE_I && RD_I && ADDR_I == 16'h0100 |=> RDATA_O == 16'h0000)
    else $error("unmapped read nonzero");
  a_circ_start_even: assert property (
    CE_I && RD_I && (ADDR_I == OFS_XC_START || ADDR_I == OFS_YC_START) |=> !RDATA_O[0])
    else $error("circular start bit 0 set");
  a_circ_end_odd: assert property (
    CE_I && RD_I && (ADDR_I == OFS_XC_END || ADDR_I == OFS_YC_END) |=> RDATA_O[0])
    else $error("circular end bit 0 clear");
  a_odd_word_trap: assert property (
    CE_I && XREQ_I.valid && XREQ_I.word && XREQ_I.mode == CRM_MODE_LINEAR && XREQ_I.base[0]
    |=> ADDR_TRAP_O)
    else $error("odd word access without trap");
  a_odd_store_off: assert property (
    CE_I && XREQ_I.valid && XREQ_I.write && XREQ_I.word && XREQ_I.mode == CRM_MODE_LINEAR
    && XREQ_I.base[0] |=> XRSP_O.valid && !XRSP_O.write_ok)
    else $error("odd word store not suppressed");
  a_trap_cause: assert property (
    $rose(ADDR_TRAP_O) |-> $past(XREQ_I.valid) || $past(YREQ_I.valid))
    else $error("address trap without request");
  a_sec_refuse: assert property (
    CE_I && YREQ_I.valid && (YREQ_I.write || !YREQ_I.word || !YREQ_I.mac_read
    || YREQ_I.prog_space) |=> !YRSP_O.valid)
    else $error("secondary accepted illegal request");
  a_sec_no_write: assert property (
    YRSP_O.valid && $past(CE_I) |-> !YRSP_O.write_ok && $past(YREQ_I.word)
    && !$past(YREQ_I.write))
    else $error("secondary granted a write");
  a_prim_linear: assert property (
    CE_I && XREQ_I.valid && XREQ_I.mode == CRM_MODE_LINEAR |=> XRSP_O.valid
    && XRSP_O.addr == $past(XREQ_I.base) && XRSP_O.next_ptr == x_sum)
    else $error("primary linear address wrong");
  a_sec_linear: assert property (
    CE_I && YREQ_I.valid && YREQ_I.word && YREQ_I.mac_read && !YREQ_I.write
    && !YREQ_I.prog_space && !YREQ_I.base[0] && YREQ_I.mode == CRM_MODE_LINEAR
    |=> YRSP_O.valid && YRSP_O.addr == $past(YREQ_I.base))
    else $error("secondary linear address wrong");

  c_stack_trap: cover property (STACK_TRAP_O);
  c_addr_trap: cover property (ADDR_TRAP_O);
  c_irq: cover property (IRQ_O);
endmodule

bind crm_core_regs crm_core_regs_properties i_props (
  .CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .XREQ_I(XREQ_I), .YREQ_I(YREQ_I),
  .XRSP_O(XRSP_O), .YRSP_O(YRSP_O), .STACK_OP_I(STACK_OP_I), .ADDR_TRAP_O(ADDR_TRAP_O),
  .STACK_TRAP_O(STACK_TRAP_O), .IRQ_O(IRQ_O)
);

//--- bench/testbench.sv
// Testbench: core register file, generators, stack and traps
module testbench
  import crm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [15:0] a; logic w; logic [15:0] d; logic [15:0] e;} crm_row_t;

  logic          CLK_I, RST_I, CE_I, WR_I, RD_I, ADDR_TRAP_O, STACK_TRAP_O, IRQ_O, t_a, t_b;
  logic [15:0]   ADDR_I, WDATA_I, RDATA_O, rd_val;
  crm_agu_req_t  XREQ_I, YREQ_I;
  crm_agu_rsp_t  XRSP_O, YRSP_O;
  crm_stack_op_t STACK_OP_I;
  int            bad_count, n_tests, cycles;
  logic [4:0]    y_bad [4] = '{5'b11110, 5'b10010, 5'b10100, 5'b10111};
  crm_row_t      rows [18] = '{
    {16'h001E, 1'b0, 16'h0, 16'h0800}, {16'h0044, 1'b0, 16'h0, 16'h0020},
    {16'h004A, 1'b0, 16'h0, 16'h0001}, {16'h0012, 1'b1, 16'hA5A5, 16'hA5A5},
    {16'h0030, 1'b1, 16'hFFFF, 16'h007F}, {16'h0032, 1'b1, 16'hFFFF, 16'h007F},
    {16'h0034, 1'b1, 16'hFFFF, 16'h00FF}, {16'h003A, 1'b1, 16'hFFFF, 16'hFFFE},
    {16'h003C, 1'b1, 16'hFFFF, 16'h007F}, {16'h0044, 1'b1, 16'hFFFF, 16'h1FFF},
    {16'h0046, 1'b1, 16'hFFFF, 16'hCFFF}, {16'h0052, 1'b1, 16'hFFFF, 16'h3FFF},
    {16'h0750, 1'b1, 16'hFFFF, 16'h0007}, {16'h0752, 1'b1, 16'hFFFF, 16'h0007},
    {16'h0048, 1'b1, 16'hFFFF, 16'hFFFE}, {16'h004E, 1'b1, 16'h1234, 16'h1235},
    {16'h0100, 1'b1, 16'hFFFF, 16'h0000}, {16'h0026, 1'b1, 16'h0080, 16'hFF80}};

  crm_core_regs i_dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .XREQ_I(XREQ_I), .YREQ_I(YREQ_I),
    .XRSP_O(XRSP_O), .YRSP_O(YRSP_O), .STACK_OP_I(STACK_OP_I), .ADDR_TRAP_O(ADDR_TRAP_O),
    .STACK_TRAP_O(STACK_TRAP_O), .IRQ_O(IRQ_O));

  initial begin
    CLK_I = 1'b0;
    forever #12.5 CLK_I = ~CLK_I;
  end

  // ------------------------------------------------------------
  // Bus, generator and stack tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    n_tests++;
    if (seen !== expd) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge CLK_I);
    WR_I <= 1'b1;
    ADDR_I <= a;
    WDATA_I <= d;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a);
    @(posedge CLK_I);
    RD_I <= 1'b1;
    ADDR_I <= a;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1 rd_val = RDATA_O;
  endtask

  task automatic gen(input crm_agu_req_t x, input crm_agu_req_t y);
    @(posedge CLK_I);
    XREQ_I <= x;
    YREQ_I <= y;
    @(posedge CLK_I);
    XREQ_I <= '0;
    YREQ_I <= '0;
    #1;
  endtask

  task automatic stack(input crm_stack_op_t op);
    @(posedge CLK_I);
    STACK_OP_I <= op;
    @(posedge CLK_I);
    STACK_OP_I <= CRM_OP_NONE;
    #1 t_a = STACK_TRAP_O;
    @(posedge CLK_I);
    #1 t_b = STACK_TRAP_O;
  endtask

  // Flags are valid, write, word, mac_read, prog_space
  function automatic crm_agu_req_t req(input logic [4:0] f, input crm_mode_t m,
                                       input logic [15:0] b, input logic [15:0] s);
    req = {f, m, b, s};
  endfunction

  task automatic report_and_stop;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop;
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    RST_I = 1'b1;
    CE_I = 1'b1;
    WR_I = 1'b0;
    RD_I = 1'b0;
    ADDR_I = 16'h0000;
    WDATA_I = 16'h0000;
    XREQ_I = '0;
    YREQ_I = '0;
    STACK_OP_I = CRM_OP_NONE;
    repeat (3) @(posedge CLK_I);
    RST_I <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) reg_wr(rows[i].a, rows[i].d);
      reg_rd(rows[i].a);
      check(rd_val, rows[i].e);
    end
    gen(req(5'b10100, CRM_MODE_LINEAR, 16'h1000, 16'h0002),
        req(5'b10110, CRM_MODE_LINEAR, 16'h2000, 16'h0004));
    check(XRSP_O.next_ptr, 16'h1002);
    check({15'h0, YRSP_O.valid}, 16'h0001);
    check(YRSP_O.next_ptr, 16'h2004);
    foreach (y_bad[i]) begin
      gen('0, req(y_bad[i], CRM_MODE_LINEAR, 16'h2000, 16'h0002));
      check({15'h0, YRSP_O.valid}, 16'h0000);
    end
    gen(req(5'b10100, CRM_MODE_LINEAR, 16'h1001, 16'h0002), '0);
    check({15'h0, ADDR_TRAP_O}, 16'h0001);
    gen(req(5'b11100, CRM_MODE_LINEAR, 16'h1001, 16'h0002), '0);
    check({14'h0, ADDR_TRAP_O, XRSP_O.write_ok}, 16'h0002);
    gen(req(5'b11100, CRM_MODE_LINEAR, 16'h1000, 16'h0002), '0);
    check({14'h0, ADDR_TRAP_O, XRSP_O.write_ok}, 16'h0001);
    reg_wr(OFS_XC_START, 16'h1000);
    reg_wr(OFS_XC_END, 16'h1002);
    reg_wr(OFS_CIRC_CTL, 16'h8000);
    for (int p = 0; p < 2; p++) begin
      gen(req({4'b1010, p[0]}, CRM_MODE_CIRC, 16'h1002, 16'h0002), '0);
      check(XRSP_O.next_ptr, 16'h1000);
    end
    reg_wr(OFS_BREV_CTL, 16'h8008);
    gen(req(5'b10101, CRM_MODE_BREV, 16'h1000, 16'h0002), '0);
    check(XRSP_O.next_ptr, 16'h1002);
    reg_wr(OFS_STK_LIMIT, 16'h1FFE);
    reg_wr(OFS_STACK_PTR, 16'h1FFE);
    stack(CRM_OP_PUSH);
    check({15'h0, t_a | t_b}, 16'h0000);
    reg_rd(OFS_STACK_PTR);
    check(rd_val, 16'h2000);
    stack(CRM_OP_PUSH);
    check({15'h0, t_a | t_b}, 16'h0001);
    stack(CRM_OP_POP);
    stack(CRM_OP_POP);
    reg_rd(OFS_STACK_PTR);
    check(rd_val, 16'h1FFE);
    reg_wr(OFS_STK_LIMIT, 16'h0000);
    reg_wr(OFS_STACK_PTR, 16'h07FE);
    repeat (2) @(posedge CLK_I);
    #1 check({15'h0, STACK_TRAP_O}, 16'h0001);
    reg_wr(OFS_STACK_PTR, 16'h0900);
    reg_rd(OFS_TRAP_STAT);
    check(rd_val, 16'h0007);
    check({15'h0, IRQ_O}, 16'h0000);
    reg_wr(OFS_TRAP_MASK, 16'h0002);
    #1 check({15'h0, IRQ_O}, 16'h0001);
    reg_wr(OFS_TRAP_STAT, 16'h0002);
    #1 check({15'h0, IRQ_O}, 16'h0000);
    reg_rd(OFS_TRAP_STAT);
    check(rd_val, 16'h0005);
    @(posedge CLK_I);
    RST_I <= 1'b1;
    @(posedge CLK_I);
    RST_I <= 1'b0;
    reg_rd(OFS_STACK_PTR);
    check(rd_val, 16'h0800);
    reg_rd(OFS_TRAP_STAT);
    check(rd_val, 16'h0000);
    report_and_stop;
  end
endmodule
